// File: rtl/swl_latch.sv
/*
  Serial memory slave core around the write-enable latch: command decode, 512 x 8 array,
  status register. SPI mode 0/3, msb first. Assumes sck, cs and si are asynchronous pins
  sampled at 20 MHz, with the serial clock well below a quarter of that rate.
*/
`timescale 1ns/1ps
`default_nettype none
`include "swl_params.svh"

module swl_latch
  import swl_pkg::*;
#(
  parameter int PU_DELAY_CYC = `SWL_PU_DELAY_CYC
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // serial link pins
  input  wire logic cs_b_i,
  input  wire logic sck_i,
  input  wire logic si_i,
  output logic      so_o,
  output logic      so_oe_o,
  // observation
  output logic      write_enable_latch_o,
  output logic      powerup_ready_o
);
  // ----------------------------------------
  // pin sampling
  // ----------------------------------------
  logic [2:0] lvl;
  logic [2:0] rise;
  logic [2:0] fall;

  swl_pin_sync #(.W(3)) u_sync (
    .clk_i  (clk_i),
    .rst_b_i(rst_b_i),
    .pin_i  ({si_i, sck_i, cs_b_i}),
    .lvl_o  (lvl),
    .rise_o (rise),
    .fall_o (fall)
  );

  logic cs_act;
  logic cs_end;
  logic sck_rise;
  logic sck_fall;
  logic si_s;
  assign cs_act   = ~lvl[0];
  assign cs_end   = rise[0];
  assign sck_rise = rise[1] & cs_act;
  assign sck_fall = fall[1] & cs_act;
  assign si_s     = lvl[2];

  // ----------------------------------------
  // opcode decode
  // ----------------------------------------
  function automatic swl_opc_t decode(input logic [7:0] op);
    unique case (op)
      `SWL_OP_SET_WE:              decode = SWL_OPC_SETWE;
      `SWL_OP_CLR_WE:              decode = SWL_OPC_CLRWE;
      `SWL_OP_STAT_RD:             decode = SWL_OPC_SRD;
      `SWL_OP_STAT_WR:             decode = SWL_OPC_SWR;
      `SWL_OP_WR_LO, `SWL_OP_WR_HI: decode = SWL_OPC_WR;
      `SWL_OP_RD_LO, `SWL_OP_RD_HI: decode = SWL_OPC_RD;
      default:                     decode = SWL_OPC_NONE;
    endcase
  endfunction

  // ----------------------------------------
  // power-up guard
  // ----------------------------------------
  // frames before the host's wait has run out are dropped as illegal
  logic [$clog2(PU_DELAY_CYC+1)-1:0] pu_cnt_q;
  logic                              pu_ready_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pu_cnt_q   <= '0;
      pu_ready_q <= 1'b0;
    end else if (!pu_ready_q) begin
      pu_cnt_q   <= pu_cnt_q + 1'b1;
      pu_ready_q <= (pu_cnt_q == ($clog2(PU_DELAY_CYC+1))'(PU_DELAY_CYC - 1));
    end
  end
  assign powerup_ready_o = pu_ready_q;

  // ----------------------------------------
  // shift engine and sequencer
  // ----------------------------------------
  swl_state_t  state_q;
  logic [7:0]  sh_q;
  logic [2:0]  bit_q;
  logic [7:0]  op_q;
  logic [8:0]  addr_q;
  logic [7:0]  tx_q;
  logic        wrote_q;  // a write took effect in this frame
  logic        we_latch_q;
  logic        cmd1_q;   // exactly one whole byte so far in this frame
  logic [1:0]  bp_q;
  logic [7:0]  mem_q [512];

  logic [7:0] rx_byte;
  logic       byte_done;
  assign rx_byte   = {sh_q[6:0], si_s};
  assign byte_done = sck_rise & (bit_q == 3'h7);

  logic [7:0] status;
  always_comb begin
    status = 8'h00;
    status[`SWL_ST_WE_LATCH_BIT] = we_latch_q;
    status[`SWL_ST_BP0_BIT] = bp_q[0];
    status[`SWL_ST_BP1_BIT] = bp_q[1];
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= SWL_IDLE;
      sh_q    <= 8'h00;
      bit_q   <= 3'h0;
      op_q    <= 8'h00;
      addr_q  <= 9'h000;
    end else if (!cs_act) begin
      state_q <= SWL_IDLE;
      bit_q   <= 3'h0;
    end else if (state_q == SWL_IDLE) begin
      state_q <= pu_ready_q ? SWL_OPCODE : SWL_IGNORE;
    end else if (sck_rise) begin
      sh_q  <= rx_byte;
      bit_q <= bit_q + 3'h1;
      if (byte_done) begin
        unique case (state_q)
          SWL_OPCODE: begin
            op_q <= rx_byte;
            addr_q[8] <= rx_byte[`SWL_OP_A8_BIT];
            unique case (decode(rx_byte))
              SWL_OPC_WR:  state_q <= we_latch_q ? SWL_ADDR : SWL_IGNORE;
              SWL_OPC_RD:  state_q <= SWL_ADDR;
              SWL_OPC_SRD: state_q <= SWL_RDATA;
              SWL_OPC_SWR: state_q <= we_latch_q ? SWL_SWR : SWL_IGNORE;
              default:     state_q <= SWL_IGNORE;
            endcase
          end
          SWL_ADDR: begin
            addr_q[7:0] <= rx_byte;
            state_q <= (decode(op_q) == SWL_OPC_WR) ? SWL_WDATA : SWL_RDATA;
          end
          SWL_WDATA: addr_q <= addr_q + 9'h001;
          SWL_RDATA: if (decode(op_q) == SWL_OPC_RD) addr_q <= addr_q + 9'h001;
          SWL_SWR:    state_q <= SWL_IGNORE;
          SWL_IGNORE: state_q <= SWL_IGNORE;
          SWL_IDLE:   state_q <= SWL_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // array and block-protect bits
  // ----------------------------------------
  // block-protect bits are stored only; array protection is outside this block
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bp_q <= `SWL_BP_RST;
    end else if (byte_done && state_q == SWL_SWR) begin
      bp_q <= {rx_byte[`SWL_ST_BP1_BIT], rx_byte[`SWL_ST_BP0_BIT]};
    end
  end

  // array has no reset: nonvolatile content is not cleared by power-up
  always_ff @(posedge clk_i) begin
    if (byte_done && state_q == SWL_WDATA) begin
      mem_q[addr_q] <= rx_byte;
    end
  end

  // ----------------------------------------
  // write-enable latch
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wrote_q <= 1'b0;
    end else if (cs_end) begin
      wrote_q <= 1'b0;
    end else if (byte_done && (state_q == SWL_WDATA || state_q == SWL_SWR)) begin
      wrote_q <= 1'b1;
    end
  end

  // one-byte commands count only if cs rises right after the eighth bit
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd1_q <= 1'b0;
    end else if (!cs_act) begin
      cmd1_q <= 1'b0;
    end else if (sck_rise) begin
      cmd1_q <= byte_done && (state_q == SWL_OPCODE);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      we_latch_q <= `SWL_WE_LATCH_RST;
    end else if (cs_end && cmd1_q) begin
      if (decode(op_q) == SWL_OPC_SETWE) begin
        we_latch_q <= 1'b1;
      end else if (decode(op_q) == SWL_OPC_CLRWE) begin
        we_latch_q <= 1'b0;
      end
    end else if (cs_end && wrote_q && op_q != `SWL_OP_WR_HI) begin
      // opcode 0x0A write cycles do not clear the latch, as in silicon
      we_latch_q <= 1'b0;
    end
  end
  assign write_enable_latch_o = we_latch_q;

  // ----------------------------------------
  // serial output
  // ----------------------------------------
  logic [7:0] tx_load;
  assign tx_load = (decode(op_q) == SWL_OPC_SRD) ? status : mem_q[addr_q];

  // first bit of each byte taken straight from tx_load: a copy made
  // before the address byte ended would be stale
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_q    <= 8'h00;
      so_o    <= 1'b0;
      so_oe_o <= 1'b0;
    end else if (!cs_act || state_q != SWL_RDATA) begin
      so_oe_o <= 1'b0;
      so_o    <= 1'b0;
      tx_q    <= 8'h00;
    end else if (sck_fall) begin
      so_oe_o <= 1'b1;
      if (bit_q == 3'h0) begin
        so_o <= tx_load[7];
        tx_q <= {tx_load[6:0], 1'b0};
      end else begin
        so_o <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end
endmodule // swl_latch
`default_nettype wire

// File: rtl/swl_params.svh
/*
  Constants of the write-enable latch block of a 512 x 8 serial memory: opcodes, status field positions,
  reset values and timing counts. Assumes a 20 MHz system clock.
*/
`ifndef SWL_PARAMS_SVH
`define SWL_PARAMS_SVH

// ----------------------------------------
// opcodes
// ----------------------------------------
`define SWL_OP_SET_WE      8'h06
`define SWL_OP_CLR_WE      8'h04
`define SWL_OP_STAT_RD     8'h05
`define SWL_OP_STAT_WR     8'h01
`define SWL_OP_WR_LO       8'h02
`define SWL_OP_WR_HI       8'h0A
`define SWL_OP_RD_LO       8'h03
`define SWL_OP_RD_HI       8'h0B
`define SWL_OP_A8_BIT      3

// ----------------------------------------
// status register fields and reset values
// ----------------------------------------
`define SWL_ST_WE_LATCH_BIT 1
`define SWL_ST_BP0_BIT     2
`define SWL_ST_BP1_BIT     3
`define SWL_WE_LATCH_RST   1'b0
`define SWL_BP_RST         2'h0

// ----------------------------------------
// timing
// ----------------------------------------
`define SWL_CLK_HZ         20000000
`define SWL_PU_DELAY_MS    1
`define SWL_PU_DELAY_CYC   ((`SWL_PU_DELAY_MS * `SWL_CLK_HZ + 999) / 1000)

`endif

// File: rtl/swl_pkg.sv
/*
  Types of the write-enable latch block. Assumes swl_params.svh is on the include path.
*/
`default_nettype none
package swl_pkg;
  typedef enum logic [2:0] {
    SWL_IDLE,
    SWL_OPCODE,
    SWL_ADDR,
    SWL_WDATA,
    SWL_RDATA,
    SWL_SWR,
    SWL_IGNORE
  } swl_state_t;

  typedef enum logic [2:0] {
    SWL_OPC_NONE,
    SWL_OPC_SETWE,
    SWL_OPC_CLRWE,
    SWL_OPC_SRD,
    SWL_OPC_SWR,
    SWL_OPC_WR,
    SWL_OPC_RD
  } swl_opc_t;
endpackage
`default_nettype wire

// File: rtl/swl_pin_sync.sv
/*
  Two-flop synchroniser plus edge detect for the serial pins.
  Assumes pins are asynchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module swl_pin_sync #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  // pins
  input  wire logic [W-1:0] pin_i,
  // synchronised level and edges
  output logic      [W-1:0] lvl_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);
  logic [W-1:0] m1_q;
  logic [W-1:0] m2_q;
  logic [W-1:0] m3_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      m1_q <= '1;
      m2_q <= '1;
      m3_q <= '1;
    end else begin
      m1_q <= pin_i;
      m2_q <= m1_q;
      m3_q <= m2_q;
    end
  end

  // edges compare only the second and third flops
  assign lvl_o  = m2_q;
  assign rise_o = m2_q & ~m3_q;
  assign fall_o = ~m2_q & m3_q;
endmodule // swl_pin_sync
`default_nettype wire

// File: testbench/swl_latch_checker.sv
/* Assertions on the ports of swl_latch.
   Assumes the serial pins move only on clk_i edges. */
`timescale 1ns/1ps
`default_nettype none
module swl_latch_checker #(
  parameter int PU_DELAY_CYC = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // pins and observation
  input wire logic cs_b_i,
  input wire logic sck_i,
  input wire logic si_i,
  input wire logic so_o,
  input wire logic so_oe_o,
  input wire logic write_enable_latch_o,
  input wire logic powerup_ready_o
);
  // ----------------
  // frame tracker
  // ----------------
  logic       sck_q;
  logic [7:0] sh_q;
  logic [7:0] op_q;
  logic [5:0] n_q;
  int         cnt_q;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sck_q <= 1'b0;
      sh_q  <= 8'h00;
      op_q  <= 8'h00;
      n_q   <= 6'h00;
      cnt_q <= 0;
    end else begin
      sck_q <= sck_i;
      cnt_q <= powerup_ready_o ? cnt_q : cnt_q + 1;
      // count kept through the edge that sees cs rise
      if (cs_b_i) begin
        n_q <= 6'h00;
      end else if (sck_i && !sck_q) begin
        sh_q <= {sh_q[6:0], si_i};
        n_q  <= n_q + 6'h01;
        if (n_q == 6'h07) begin
          op_q <= {sh_q[6:0], si_i};
        end
      end
    end
  end
  // ----------------
  // assertions
  // ----------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence frame_end;
    $rose(cs_b_i);
  endsequence
  sequence cmd_end(logic [7:0] op);
    frame_end ##0 (op_q == op && n_q == 6'h08 && powerup_ready_o);
  endsequence
  ready_time_a: assert property ($rose(powerup_ready_o) |-> cnt_q inside {[PU_DELAY_CYC-1:PU_DELAY_CYC+2]})
    else $error("ready flag off time");
  latch_pwr_a: assert property (!powerup_ready_o |-> !write_enable_latch_o)
    else $error("latch set before ready");
  rise_cause_a: assert property ($rose(write_enable_latch_o) |-> op_q == 8'h06)
    else $error("latch set without enable");
  fall_cause_a: assert property ($fell(write_enable_latch_o) |-> op_q inside {8'h01, 8'h02, 8'h04})
    else $error("latch cleared by wrong command");
  set_cmd_a: assert property (cmd_end(8'h06) |-> ##[1:5] write_enable_latch_o)
    else $error("enable not taken");
  clr_cmd_a: assert property (cmd_end(8'h04) |-> ##[1:5] !write_enable_latch_o)
    else $error("clear not taken");
  wr_clear_a: assert property (frame_end ##0 (write_enable_latch_o &&
    ((op_q == 8'h01 && n_q >= 6'h10) || (op_q == 8'h02 && n_q >= 6'h18))) |-> ##[1:5] !write_enable_latch_o)
    else $error("write left latch set");
  hi_keep_a: assert property (frame_end ##0 (op_q == 8'h0A && write_enable_latch_o) |=> write_enable_latch_o [*6])
    else $error("upper write cleared latch");
  drive_read_a: assert property (so_oe_o |-> op_q inside {8'h03, 8'h05, 8'h0B})
    else $error("output driven outside read");
endmodule // swl_latch_checker
`default_nettype wire

// File: testbench/swl_host_model.sv
/* Host side of the serial link, mode 0, msb first.
   Assumes clk_i is the 20 MHz bench clock. */
`timescale 1ns/1ps
`default_nettype none
module swl_host_model (
  // clock
  input  wire logic clk_i,
  // serial link
  output logic      cs_b_o,
  output logic      sck_o,
  output logic      si_o,
  input  wire logic so_i
);
  // ----------------
  // frame engine
  // ----------------
  initial begin
    cs_b_o = 1'b1;
    sck_o  = 1'b0;
    si_o   = 1'b0;
  end
  // half of the 400 ns link period
  task automatic half();
    repeat (4) @(posedge clk_i);
  endtask
  // so sampled late in the high phase, clear of its change after the fall
  task automatic frame(input logic [31:0] d, input int n, output logic [7:0] rd);
    rd = 8'h00;
    cs_b_o <= 1'b0;
    for (int i = 0; i < n; i++) begin
      si_o <= d[31-i];
      half();
      sck_o <= 1'b1;
      half();
      rd = {rd[6:0], so_i};
      sck_o <= 1'b0;
    end
    half();
    cs_b_o <= 1'b1;
    si_o <= ~si_o;
    repeat (8) @(posedge clk_i);
  endtask
endmodule // swl_host_model
`default_nettype wire

// File: testbench/swl_latch_tb.sv
/* Self-checking bench of swl_latch driven by the host model.
   Assumes the checker and host model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module swl_latch_tb;
  // ----------------
  // harness
  // ----------------
  logic       clk_i = 1'b0;
  logic       rst_b_i = 1'b0;
  logic       cs_b, sck, si, so, so_oe, latch, rdy;
  logic [7:0] rd;
  int         n_mismatch = 0;
  int         num_checks = 0;
  always #25 clk_i = ~clk_i;
  swl_latch #(.PU_DELAY_CYC(8)) DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b), .sck_i(sck), .si_i(si),
    .so_o(so), .so_oe_o(so_oe), .write_enable_latch_o(latch), .powerup_ready_o(rdy));
  // undriven so line reads inverted, so a missing enable shows up as bad data
  swl_host_model host (.clk_i(clk_i), .cs_b_o(cs_b), .sck_o(sck), .si_o(si), .so_i(so_oe ? so : ~so));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic send(input logic [31:0] d, input int n);
    host.frame(d, n, rd);
  endtask
  task automatic st(input logic [7:0] e, input string nm);
    send({8'h05, 24'h0}, 16);
    `CHK(nm, e, rd)
    `CHK(nm, e[1], latch)
  endtask
  // ----------------
  // tests
  // ----------------
  task automatic t_status();
    st(8'h00, "pwr");
    send({8'h01, 8'h0E, 16'h0}, 16);
    st(8'h00, "swr_off");
    send({8'h06, 24'h0}, 8);
    st(8'h02, "set");
    send({8'h01, 8'h0E, 16'h0}, 16);
    st(8'h0C, "swr_on");
    $display("test status done");
  endtask
  task automatic t_low();
    send({8'h06, 24'h0}, 8);
    send({8'h02, 8'h10, 8'h3C, 8'h0}, 24);
    st(8'h0C, "wr_lo");
    send({8'h02, 8'h10, 8'h99, 8'h0}, 24);
    send({8'h03, 8'h10, 16'h0}, 24);
    `CHK("rd_lo", 8'h3C, rd)
    $display("test low done");
  endtask
  task automatic t_high();
    send({8'h06, 24'h0}, 8);
    send({8'h0A, 8'h10, 8'h5A, 8'h0}, 24);
    st(8'h0E, "wr_hi");
    send({8'h0A, 8'hFF, 8'hA5, 8'h0}, 24);
    send({8'h0B, 8'hFF, 16'h0}, 24);
    `CHK("rd_top", 8'hA5, rd)
    send({8'h03, 8'h10, 16'h0}, 24);
    `CHK("rd_lo2", 8'h3C, rd)
    send({8'h0B, 8'h10, 16'h0}, 24);
    `CHK("rd_hi", 8'h5A, rd)
    $display("test high done");
  endtask
  task automatic t_clear();
    send({8'h04, 24'h0}, 8);
    st(8'h0C, "clr");
    send({8'h0A, 8'hFF, 8'h11, 8'h0}, 24);
    send({8'h0B, 8'hFF, 16'h0}, 24);
    `CHK("rd_kept", 8'hA5, rd)
    $display("test clear done");
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 50 && rdy !== 1'b1; i++) @(posedge clk_i);
    `CHK("ready", 1'b1, rdy)
    t_status();
    t_low();
    t_high();
    t_clear();
    give_verdict();
  end
  initial begin
    #2000000;
    n_mismatch++;
    give_verdict();
  end
endmodule // swl_latch_tb
bind swl_latch swl_latch_checker #(.PU_DELAY_CYC(PU_DELAY_CYC)) u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .cs_b_i(cs_b_i), .sck_i(sck_i), .si_i(si_i), .so_o(so_o), .so_oe_o(so_oe_o),
  .write_enable_latch_o(write_enable_latch_o), .powerup_ready_o(powerup_ready_o));
`default_nettype wire
